// [logic/tss_defs.svh]
// Offsets, field positions, limits and reset values of the test-signal setup block
`ifndef TSS_DEFS_SVH
`define TSS_DEFS_SVH
`define TSS_OFF_CMD      8'h00
`define TSS_OFF_ARG      8'h04
`define TSS_OFF_KWORD    8'h08
`define TSS_OFF_STATUS   8'h0C
`define TSS_OFF_RVAL     8'h10
`define TSS_OFF_RINFO    8'h14
`define TSS_OFF_FREQ     8'h18
`define TSS_OFF_LEVEL    8'h1C
`define TSS_CMD_ID_HI    3
`define TSS_CMD_QRY      4
`define TSS_ST_EXEC      0
`define TSS_ST_QRY       1
`define TSS_ST_RESP      2
`define TSS_ST_COMP      3
`define TSS_ST_RNG       4
`define TSS_ST_LVL       5
`define TSS_ST_W1C       3'h7
`define TSS_KW_ON        32'h4F4E0000
`define TSS_KW_OFF       32'h4F464600
`define TSS_KW_V         32'h56000000
`define TSS_KW_CV        32'h43560000
`define TSS_KW_CC        32'h43430000
`define TSS_FREQ_HF_MIN  32'h000001A4
`define TSS_FREQ_HF_MAX  32'h02FAF080
`define TSS_FREQ_LF_MIN  32'h00000000
`define TSS_FREQ_LF_MAX  32'h000F4240
`define TSS_FREQ_100K    32'h000F4240
`define TSS_FREQ_1M      32'h00989680
`define TSS_I_MIN        32'h00000001
`define TSS_I_MAX        32'h0000270F
`define TSS_I_MAX_HF     32'h000007D0
`define TSS_V_MIN        32'h0000000A
`define TSS_V_MAX        32'h00001388
`define TSS_V_MAX_HF     32'h000003E8
`define TSS_RND_F        33'h00000000A
`define TSS_RND_I        33'h000002710
`define TSS_RST_FREQ     32'h00002710
`define TSS_RST_I        32'h00000064
`define TSS_RST_V        32'h000003E8
`define TSS_RESP_MAX     9'h12C
`define TSS_LEN_NR3      9'h009
`define TSS_LEN_NR2      9'h005
`define TSS_RI_PFX       2
`define TSS_RI_ID_LO     3
`define TSS_RI_LEN_LO    8
`endif

// [logic/tss_pkg.sv]
// Types shared by the test-signal setup block
package tss_pkg;
    typedef enum logic [3:0] {
        TSS_FREQ, TSS_HEADER, TSS_LEVEL, TSS_CCUR, TSS_CVOLT,
        TSS_OVOLT, TSS_CLAMP, TSS_CLAMP_I, TSS_CLAMP_V
    } tss_cmd_e;
    typedef enum logic [1:0] {
        open_voltage_drive, const_voltage_drive, const_current_drive
    } tss_drive_e;
    typedef enum logic [1:0] {TSS_FMT_NR2, TSS_FMT_NR3, TSS_FMT_CHAR} tss_fmt_e;
    typedef struct packed {
        logic [31:0] freq;      // 0.1 Hz units
        logic        prefix_on;
        tss_drive_e  drive;
        logic [31:0] cc;        // 10 uA units
        logic [31:0] cv;        // 1 mV units
        logic [31:0] ov;        // 1 mV units
        logic        clamp_on;
        logic [31:0] clamp_i;   // 10 uA units
        logic [31:0] clamp_v;   // 1 mV units
    } tss_set_s;
    typedef struct packed {
        logic [31:0] value;
        tss_fmt_e    fmt;
        logic        prefix;
        logic [3:0]  id;
        logic [8:0]  len;
    } tss_resp_s;
endpackage : tss_pkg

// [logic/tss_top.sv]
// Test-signal setup command interpreter with APB register access
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "tss_defs.svh"
module tss_top #(
    parameter bit HIGH_FREQ_VARIANT = 1'b1
) (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // APB slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // Instrument side
    input  wire logic              comp_active,
    output tss_pkg::tss_set_s      settings,
    output logic                   range_restrict,
    output logic                   level_restrict
);

    tss_pkg::tss_set_s  set_q, set_d;
    tss_pkg::tss_resp_s resp_q, resp_d;
    logic [31:0]        arg_q;
    logic [31:0]        kw_q;
    logic [4:0]         cmd_q;
    logic [2:0]         st_q, st_d;
    logic               rng_q, rng_d;
    logic               lvl_q, lvl_d;
    logic [31:0]        prdata_q;

    // Rounding divide: drops digits finer than the stored resolution
    function automatic logic [31:0] rnd_div(input logic [31:0] a, input logic [32:0] d);
        logic [32:0] t;
        t = ({1'b0, a} + (d >> 1)) / d;
        return t[31:0];
    endfunction : rnd_div

    // Case folding of one ASCII byte
    function automatic logic [7:0] to_upper(input logic [7:0] c);
        return (c >= 8'h61 && c <= 8'h7A) ? (c - 8'h20) : c;
    endfunction : to_upper

    // Inclusive window test used by every numeric setting
    function automatic logic in_win(input logic [31:0] v, input logic [31:0] lo,
                                    input logic [31:0] hi);
        return (v >= lo) && (v <= hi);
    endfunction : in_win

    // Length of the upper-case header including colon and trailing space
    function automatic logic [8:0] hdr_len(input logic [3:0] id);
        unique case (id)
            tss_pkg::TSS_FREQ:    return 9'h00B;
            tss_pkg::TSS_HEADER:  return 9'h008;
            tss_pkg::TSS_LEVEL:   return 9'h007;
            tss_pkg::TSS_CCUR:    return 9'h010;
            tss_pkg::TSS_CVOLT:   return 9'h010;
            tss_pkg::TSS_OVOLT:   return 9'h00F;
            tss_pkg::TSS_CLAMP:   return 9'h009;
            default:              return 9'h011;
        endcase
    endfunction : hdr_len

    // Length of a keyword answer, counting characters up to the first zero byte
    function automatic logic [8:0] kw_len(input logic [31:0] k);
        if (k[23:16] == 8'h00)
            return 9'h001;
        else if (k[15:8] == 8'h00)
            return 9'h002;
        else
            return 9'h003;
    endfunction : kw_len

    // APB decode
    wire         apb_acc  = psel & penable;
    wire         apb_wr   = apb_acc & pwrite;
    wire         sel_cmd  = (paddr == `TSS_OFF_CMD);
    wire         sel_arg  = (paddr == `TSS_OFF_ARG);
    wire         sel_kw   = (paddr == `TSS_OFF_KWORD);
    wire         sel_st   = (paddr == `TSS_OFF_STATUS);
    wire         sel_rval = (paddr == `TSS_OFF_RVAL);
    wire         sel_rinf = (paddr == `TSS_OFF_RINFO);
    wire         sel_freq = (paddr == `TSS_OFF_FREQ);
    wire         sel_lvl  = (paddr == `TSS_OFF_LEVEL);
    wire         addr_ok  = sel_cmd | sel_arg | sel_kw | sel_st | sel_rval | sel_rinf | sel_freq | sel_lvl;
    wire         cmd_wr   = apb_wr & sel_cmd;
    wire [3:0]   cmd_id   = pwdata[`TSS_CMD_ID_HI:0];
    wire         is_qry   = pwdata[`TSS_CMD_QRY];

    // Keyword argument folded to upper case byte by byte
    logic [31:0] kw_up;
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_fold
            assign kw_up[gi*8 +: 8] = to_upper(kw_q[gi*8 +: 8]);
        end
    endgenerate

    wire         kw_on  = (kw_up == `TSS_KW_ON);
    wire         kw_off = (kw_up == `TSS_KW_OFF);
    wire         kw_v   = (kw_up == `TSS_KW_V);
    wire         kw_cv  = (kw_up == `TSS_KW_CV);
    wire         kw_cc  = (kw_up == `TSS_KW_CC);
    wire         kw_bool = kw_on | kw_off;
    wire         kw_mode = kw_v | kw_cv | kw_cc;

    // Argument rounded to the resolution of each kind of setting
    wire [31:0]  f_r = rnd_div(arg_q, `TSS_RND_F);
    wire [31:0]  v_r = rnd_div(arg_q, `TSS_RND_F);
    wire [31:0]  i_r = rnd_div(arg_q, `TSS_RND_I);

    // Frequency window per variant; zero is DC and only legal on the low variant
    wire [31:0]  f_lo = HIGH_FREQ_VARIANT ? `TSS_FREQ_HF_MIN : `TSS_FREQ_LF_MIN;
    wire [31:0]  f_hi = HIGH_FREQ_VARIANT ? `TSS_FREQ_HF_MAX : `TSS_FREQ_LF_MAX;
    wire         f_ok = in_win(f_r, f_lo, f_hi);

    // Level ceilings drop once the active frequency is past 1 MHz
    wire         hf_now = HIGH_FREQ_VARIANT && (set_q.freq > `TSS_FREQ_1M);
    wire [31:0]  i_hi   = hf_now ? `TSS_I_MAX_HF : `TSS_I_MAX;
    wire [31:0]  v_hi   = hf_now ? `TSS_V_MAX_HF : `TSS_V_MAX;
    wire         cc_ok  = in_win(i_r, `TSS_I_MIN, i_hi);
    wire         cv_ok  = in_win(v_r, `TSS_V_MIN, v_hi);
    wire         ov_ok  = in_win(v_r, `TSS_V_MIN, v_hi);
    wire         ci_ok  = in_win(i_r, `TSS_I_MIN, `TSS_I_MAX);
    wire         cvl_ok = in_win(v_r, `TSS_V_MIN, `TSS_V_MAX);

    // A new frequency above 1 MHz forces levels down to the highest legal value
    wire         f_new_hf = HIGH_FREQ_VARIANT && (f_r > `TSS_FREQ_1M);
    wire         f_new_rg = (f_r > `TSS_FREQ_100K);
    wire [31:0]  cc_cl = (f_new_hf && set_q.cc > `TSS_I_MAX_HF) ? `TSS_I_MAX_HF : set_q.cc;
    wire [31:0]  cv_cl = (f_new_hf && set_q.cv > `TSS_V_MAX_HF) ? `TSS_V_MAX_HF : set_q.cv;
    wire [31:0]  ov_cl = (f_new_hf && set_q.ov > `TSS_V_MAX_HF) ? `TSS_V_MAX_HF : set_q.ov;

    // Prefix flag itself is not blocked while compensation runs
    wire         blocked = comp_active && (cmd_id != tss_pkg::TSS_HEADER);

    // Argument legality per command
    logic        arg_ok;
    logic        id_ok;
    always_comb
    begin
        arg_ok = 1'b0;
        id_ok  = 1'b1;
        unique case (cmd_id)
            tss_pkg::TSS_FREQ:    arg_ok = f_ok;
            tss_pkg::TSS_HEADER:  arg_ok = kw_bool;
            tss_pkg::TSS_LEVEL:   arg_ok = kw_mode;
            tss_pkg::TSS_CCUR:    arg_ok = cc_ok;
            tss_pkg::TSS_CVOLT:   arg_ok = cv_ok;
            tss_pkg::TSS_OVOLT:   arg_ok = ov_ok;
            tss_pkg::TSS_CLAMP:   arg_ok = kw_bool;
            tss_pkg::TSS_CLAMP_I: arg_ok = ci_ok;
            tss_pkg::TSS_CLAMP_V: arg_ok = cvl_ok;
            default:              id_ok  = 1'b0;
        endcase
    end

    wire         do_set   = cmd_wr && !is_qry && id_ok && arg_ok && !blocked;
    wire         exec_evt = cmd_wr && ((!is_qry && (!arg_ok || blocked)) || !id_ok);

    // Keyword answers for the three keyword settings
    wire [31:0]  kw_prefix = set_q.prefix_on ? `TSS_KW_ON : `TSS_KW_OFF;
    wire [31:0]  kw_clamp  = set_q.clamp_on  ? `TSS_KW_ON : `TSS_KW_OFF;
    logic [31:0] kw_drive;
    always_comb
    begin
        unique case (set_q.drive)
            tss_pkg::const_voltage_drive: kw_drive = `TSS_KW_CV;
            tss_pkg::const_current_drive: kw_drive = `TSS_KW_CC;
            default:                      kw_drive = `TSS_KW_V;
        endcase
    end

    // Query answer: value, format and byte count
    logic [31:0]       q_val;
    tss_pkg::tss_fmt_e q_fmt;
    always_comb
    begin
        q_val = set_q.freq;
        q_fmt = tss_pkg::TSS_FMT_NR3;
        unique case (cmd_id)
            tss_pkg::TSS_HEADER:
            begin
                q_val = kw_prefix;
                q_fmt = tss_pkg::TSS_FMT_CHAR;
            end
            tss_pkg::TSS_LEVEL:
            begin
                q_val = kw_drive;
                q_fmt = tss_pkg::TSS_FMT_CHAR;
            end
            tss_pkg::TSS_CCUR:    q_val = set_q.cc;
            tss_pkg::TSS_CVOLT:
            begin
                q_val = set_q.cv;
                q_fmt = tss_pkg::TSS_FMT_NR2;
            end
            tss_pkg::TSS_OVOLT:
            begin
                q_val = set_q.ov;
                q_fmt = tss_pkg::TSS_FMT_NR2;
            end
            tss_pkg::TSS_CLAMP:
            begin
                q_val = kw_clamp;
                q_fmt = tss_pkg::TSS_FMT_CHAR;
            end
            tss_pkg::TSS_CLAMP_I: q_val = set_q.clamp_i;
            tss_pkg::TSS_CLAMP_V:
            begin
                q_val = set_q.clamp_v;
                q_fmt = tss_pkg::TSS_FMT_NR2;
            end
            default:              q_val = set_q.freq;
        endcase
    end

    wire [8:0]   val_len = (q_fmt == tss_pkg::TSS_FMT_CHAR) ? kw_len(q_val) :
                           (q_fmt == tss_pkg::TSS_FMT_NR3) ? `TSS_LEN_NR3 : `TSS_LEN_NR2;
    wire [8:0]   q_len   = val_len + (set_q.prefix_on ? hdr_len(cmd_id) : 9'h000);
    wire         q_cmd   = cmd_wr && is_qry && id_ok;
    wire         q_long  = q_cmd && (q_len > `TSS_RESP_MAX);
    wire         q_good  = q_cmd && !q_long;

    // Next settings: only a legal, unblocked command changes anything
    always_comb
    begin
        set_d = set_q;
        if (do_set)
        begin
            unique case (cmd_id)
                tss_pkg::TSS_FREQ:
                begin
                    set_d.freq = f_r;
                    set_d.cc   = cc_cl;
                    set_d.cv   = cv_cl;
                    set_d.ov   = ov_cl;
                end
                tss_pkg::TSS_HEADER:  set_d.prefix_on = kw_on;
                tss_pkg::TSS_LEVEL:
                    set_d.drive = kw_cv ? tss_pkg::const_voltage_drive :
                                  kw_cc ? tss_pkg::const_current_drive :
                                          tss_pkg::open_voltage_drive;
                tss_pkg::TSS_CCUR:    set_d.cc      = i_r;
                tss_pkg::TSS_CVOLT:   set_d.cv      = v_r;
                tss_pkg::TSS_OVOLT:   set_d.ov      = v_r;
                tss_pkg::TSS_CLAMP:   set_d.clamp_on = kw_on;
                tss_pkg::TSS_CLAMP_I: set_d.clamp_i = i_r;
                tss_pkg::TSS_CLAMP_V: set_d.clamp_v = v_r;
                default:              set_d = set_q;
            endcase
        end
    end

    // Range and level restriction follow the frequency that is actually applied
    wire         f_apply = do_set && (cmd_id == tss_pkg::TSS_FREQ);
    assign rng_d = f_apply ? f_new_rg : rng_q;
    assign lvl_d = f_apply ? f_new_hf : lvl_q;

    // Answer latch; an over-long answer leaves the old one and flags the error
    always_comb
    begin
        resp_d = resp_q;
        if (q_good)
        begin
            resp_d.value  = q_val;
            resp_d.fmt    = q_fmt;
            resp_d.prefix = set_q.prefix_on;
            resp_d.id     = cmd_id;
            resp_d.len    = q_len;
        end
    end

    // Sticky status; a new event in the cycle of its clear wins
    wire [2:0]   st_clr = (apb_wr && sel_st) ? (pwdata[2:0] & `TSS_ST_W1C) : 3'h0;
    wire [2:0]   st_set = {q_good, q_long, exec_evt};
    assign st_d = (st_q & ~st_clr) | st_set;

    // Read mux, sampled in the setup cycle so prdata comes from a flop
    logic [31:0] rd_mux;
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        if (sel_cmd)
            rd_mux = {27'h0, cmd_q};
        else if (sel_arg)
            rd_mux = arg_q;
        else if (sel_kw)
            rd_mux = kw_q;
        else if (sel_st)
            rd_mux = {26'h0, lvl_q, rng_q, comp_active, st_q};
        else if (sel_rval)
            rd_mux = resp_q.value;
        else if (sel_rinf)
            rd_mux = {15'h0, resp_q.len, 1'b0, resp_q.id, resp_q.prefix, resp_q.fmt};
        else if (sel_freq)
            rd_mux = set_q.freq;
        else if (sel_lvl)
            rd_mux = {30'h0, set_q.drive};
    end

    // Settings and answer state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            set_q.freq      <= `TSS_RST_FREQ;
            set_q.prefix_on <= 1'b0;
            set_q.drive     <= tss_pkg::open_voltage_drive;
            set_q.cc        <= `TSS_RST_I;
            set_q.cv        <= `TSS_RST_V;
            set_q.ov        <= `TSS_RST_V;
            set_q.clamp_on  <= 1'b0;
            set_q.clamp_i   <= `TSS_I_MAX;
            set_q.clamp_v   <= `TSS_V_MAX;
            resp_q          <= '0;
        end
        else
        begin
            set_q  <= set_d;
            resp_q <= resp_d;
        end
    end

    // Software-written argument registers and flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            arg_q    <= 32'h0000_0000;
            kw_q     <= 32'h0000_0000;
            cmd_q    <= 5'h00;
            st_q     <= 3'h0;
            rng_q    <= 1'b0;
            lvl_q    <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end
        else
        begin
            if (apb_wr && sel_arg)
                arg_q <= pwdata;
            if (apb_wr && sel_kw)
                kw_q <= pwdata;
            if (cmd_wr)
                cmd_q <= pwdata[`TSS_CMD_QRY:0];
            if (psel && !penable)
                prdata_q <= rd_mux;
            st_q  <= st_d;
            rng_q <= rng_d;
            lvl_q <= lvl_d;
        end
    end

    // Zero-wait slave; unmapped addresses answer with an error
    assign pready         = 1'b1;
    assign pslverr        = apb_acc & ~addr_ok;
    assign prdata         = prdata_q;
    assign settings       = set_q;
    assign range_restrict = rng_q;
    assign level_restrict = lvl_q;

endmodule : tss_top

// [testbench/tss_properties.sv]
// Port-level assertions for the test-signal setup block
`timescale 1ns/1ps
`include "tss_defs.svh"
module tss_properties #(
    parameter bit HIGH_FREQ_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // APB
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    // Instrument side
    input wire logic              comp_active,
    input wire tss_pkg::tss_set_s settings,
    input wire logic              range_restrict,
    input wire logic              level_restrict
);
    // Access-phase and command-write decode
    wire logic acc = psel && penable;
    wire logic cmd_wr = acc && pwrite && paddr == `TSS_OFF_CMD;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_ready; pready; endproperty
    a_ready: assert property (p_ready) else $error("pready low");
    property p_err_idle; !acc |-> !pslverr; endproperty
    a_err_idle: assert property (p_err_idle) else $error("pslverr outside access");
    property p_unmapped; acc && paddr > `TSS_OFF_LEVEL |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped address");
    property p_mapped; acc && paddr <= `TSS_OFF_LEVEL && paddr[1:0] == 2'h0 |-> !pslverr; endproperty
    a_mapped: assert property (p_mapped) else $error("error on mapped address");
    property p_hold; !cmd_wr |=> $stable(settings); endproperty
    a_hold: assert property (p_hold) else $error("settings moved without command");
    property p_comp; cmd_wr && comp_active && pwdata[4:0] != 5'h01 |=> $stable(settings); endproperty
    a_comp: assert property (p_comp) else $error("setting applied during compensation");
    property p_bad_id; cmd_wr && pwdata[3:0] > 4'h8 |=> $stable(settings); endproperty
    a_bad_id: assert property (p_bad_id) else $error("unknown command changed settings");
    property p_range; range_restrict == (settings.freq > `TSS_FREQ_100K); endproperty
    a_range: assert property (p_range) else $error("range restrict wrong");
    property p_level; level_restrict == (HIGH_FREQ_VARIANT && settings.freq > `TSS_FREQ_1M); endproperty
    a_level: assert property (p_level) else $error("level restrict wrong");
    property p_clamp;
        level_restrict |-> settings.cc <= `TSS_I_MAX_HF && settings.cv <= `TSS_V_MAX_HF
            && settings.ov <= `TSS_V_MAX_HF;
    endproperty
    a_clamp: assert property (p_clamp) else $error("level above high-frequency ceiling");
    property p_freq;
        HIGH_FREQ_VARIANT ? (settings.freq >= `TSS_FREQ_HF_MIN && settings.freq <= `TSS_FREQ_HF_MAX)
            : settings.freq <= `TSS_FREQ_LF_MAX;
    endproperty
    a_freq: assert property (p_freq) else $error("frequency out of range");
endmodule : tss_properties

// [testbench/tss_host.sv]
// Host model: APB master issuing register transfers
`timescale 1ns/1ps
module tss_host (
    // Clock
    input wire logic         pclk,
    // APB request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    // APB answer
    input wire logic [31:0]  prdata,
    input wire logic         pready,
    input wire logic         pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'hFF;
        pwdata = 32'hA5A5A5A5;
    end
    // One transfer; released lines show inverted data so stale values never look valid
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            tb_top.error_cnt++;
            tb_top.complete_run();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
        @(posedge pclk);
    endtask : xfer
endmodule : tss_host

// [testbench/tb_top.sv]
// Self-checking bench for the test-signal setup block
`timescale 1ns/1ps
`include "tss_defs.svh"
module tb_top;
    logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic              comp_active, range_restrict, level_restrict;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, q;
    tss_pkg::tss_set_s settings;
    int                error_cnt, checks, seed, m_f, m_d, m_cc, m_cv, m_ov, m_ci, m_cvl;
    bit                m_p, m_on;
    int hl[9] = '{11, 8, 7, 16, 16, 15, 9, 17, 17};
    // Triples of command id, argument and keyword, boundaries on both sides
    int tbl[$] = '{0, 4190, 0, 0, 4200, 0, 0, 500000010, 0, 0, 500000000, 0, 4, 10010, 0, 4, 10000, 0,
        3, 20000000, 0, 3, 20010000, 0, 0, 100000000, 0, 5, 50000, 0, 5, 50010, 0, 3, 99990000, 0,
        3, 100000000, 0, 3, 0, 0, 4, 50000, 0, 0, 200000000, 0, 1, 0, 32'h6F6E0000, 1, 0, 32'h58580000,
        2, 0, `TSS_KW_V, 2, 0, `TSS_KW_CV, 2, 0, 32'h63630000, 2, 0, 32'h58580000, 6, 0, `TSS_KW_ON,
        6, 0, `TSS_KW_OFF, 6, 0, `TSS_KW_V, 7, 1000, 0, 7, 99990000, 0, 7, 100000000, 0, 8, 100, 0,
        8, 90, 0, 8, 50000, 0, 8, 50010, 0, 9, 0, 0, 15, 0, 0, 1, 0, `TSS_KW_OFF};
    tss_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .comp_active(comp_active), .settings(settings), .range_restrict(range_restrict),
        .level_restrict(level_restrict));
    tss_host host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    always #10 pclk = ~pclk;
    task automatic chk(input bit ok, input string m);
        checks++;
        if (!ok)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    // Reset the device and the model together
    task automatic do_reset;
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        {m_f, m_p, m_d, m_cc, m_cv, m_ov, m_on, m_ci, m_cvl} = {`TSS_RST_FREQ, 1'b0, 32'h0, `TSS_RST_I,
            `TSS_RST_V, `TSS_RST_V, 1'b0, `TSS_I_MAX, `TSS_V_MAX};
    endtask : do_reset
    // Query and compare value and answer info against the model
    task automatic qry(input int id);
        logic [31:0] v;
        int f, n;
        case (id)
            0, 3, 7: {v, f, n} = {id == 0 ? m_f : id == 3 ? m_cc : m_ci, 32'd1, 32'd9};
            1, 6: {v, f, n} = {(id == 1 ? m_p : m_on) ? `TSS_KW_ON : `TSS_KW_OFF, 32'd2,
                               (id == 1 ? m_p : m_on) ? 32'd2 : 32'd3};
            2: {v, f, n} = {m_d == 0 ? `TSS_KW_V : m_d == 1 ? `TSS_KW_CV : `TSS_KW_CC, 32'd2,
                            m_d == 0 ? 32'd1 : 32'd2};
            default: {v, f, n} = {id == 4 ? m_cv : id == 5 ? m_ov : m_cvl, 32'd0, 32'd5};
        endcase
        if (m_p)
            n += hl[id];
        host.xfer(1'b1, `TSS_OFF_CMD, 32'h10 + id, q, e);
        host.xfer(1'b0, `TSS_OFF_RVAL, 32'h0, q, e);
        chk(q === v, "query value");
        host.xfer(1'b0, `TSS_OFF_RINFO, 32'h0, q, e);
        chk(q[16:0] === {n[8:0], 1'b0, id[3:0], m_p, f[1:0]}, "query info");
    endtask : qry
    // Issue one setting command, predict its effect, then compare
    task automatic cmd(input int id, input int arg, input logic [31:0] kw);
        int r, hi;
        logic [31:0] k;
        bit x;
        r = (id == 3 || id == 7) ? (arg + 5000) / 10000 : (arg + 5) / 10;
        k = kw & 32'hDFDFDFDF;
        hi = m_f > 10000000;
        x = (comp_active && id != 1) || id > 8;
        case (id)
            0: x |= r < 420 || r > 50000000;
            1, 6: x |= k != `TSS_KW_ON && k != `TSS_KW_OFF;
            2: x |= k != `TSS_KW_V && k != `TSS_KW_CV && k != `TSS_KW_CC;
            3: x |= r < 1 || r > (hi ? 2000 : 9999);
            4, 5: x |= r < 10 || r > (hi ? 1000 : 5000);
            7: x |= r < 1 || r > 9999;
            8: x |= r < 10 || r > 5000;
        endcase
        if (!x)
            case (id)
                0: {m_f, m_cc, m_cv, m_ov} = {r, (r > 10000000 && m_cc > 2000) ? 2000 : m_cc,
                    (r > 10000000 && m_cv > 1000) ? 1000 : m_cv, (r > 10000000 && m_ov > 1000) ? 1000 : m_ov};
                1: m_p = k == `TSS_KW_ON;
                2: m_d = k == `TSS_KW_V ? 0 : k == `TSS_KW_CV ? 1 : 2;
                3: m_cc = r;
                4: m_cv = r;
                5: m_ov = r;
                6: m_on = k == `TSS_KW_ON;
                7: m_ci = r;
                8: m_cvl = r;
            endcase
        host.xfer(1'b1, `TSS_OFF_ARG, arg, q, e);
        host.xfer(1'b1, `TSS_OFF_KWORD, kw, q, e);
        host.xfer(1'b1, `TSS_OFF_STATUS, 32'h7, q, e);
        host.xfer(1'b1, `TSS_OFF_CMD, id, q, e);
        host.xfer(1'b0, `TSS_OFF_STATUS, 32'h0, q, e);
        chk(q[0] === x, "execution error flag");
        chk(q[5:4] === {m_f > 10000000, m_f > 1000000}, "restrict flags");
        chk(settings === {m_f, m_p, tss_pkg::tss_drive_e'(m_d), m_cc, m_cv, m_ov, m_on, m_ci, m_cvl},
            "settings");
        if (id < 9)
            qry(id);
    endtask : cmd
    initial
    begin
        {pclk, presetn, comp_active, seed} = {1'b0, 1'b0, 1'b0, 32'd87};
        do_reset();
        chk(settings.prefix_on === 1'b0, "prefix at power-on");
        qry(1);
        repeat (6) cmd(0, 4200 + $unsigned($random(seed)) % 499995801, 0);
        for (int i = 0; i < tbl.size(); i += 3)
            cmd(tbl[i], tbl[i + 1], tbl[i + 2]);
        $display("test boundaries done");
        comp_active <= 1'b1;
        @(posedge pclk);
        cmd(0, 300000, 0);
        cmd(2, 0, `TSS_KW_CC);
        cmd(1, 0, `TSS_KW_ON);
        comp_active <= 1'b0;
        @(posedge pclk);
        cmd(8, 12340, 0);
        $display("test compensation done");
        host.xfer(1'b1, 8'h24, 32'h1, q, e);
        host.xfer(1'b0, 8'h20, 32'h0, q, e);
        chk(e === 1'b1 && q === 32'h0, "unmapped read");
        do_reset();
        qry(1);
        $display("test reset done");
        complete_run();
    end
endmodule : tb_top
bind tss_top tss_properties #(.HIGH_FREQ_VARIANT(HIGH_FREQ_VARIANT)) u_props (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .comp_active(comp_active), .settings(settings),
    .range_restrict(range_restrict), .level_restrict(level_restrict));
